// >>> pkg/wdg_map.vh
/*
 * constants for the supervision timer: register offsets, field positions,
 * reset values and timing counts.
 * assumes a 10 MHz system clock and a 128 kHz timer oscillator rate.
 */
`ifndef WDG_MAP_VH
`define WDG_MAP_VH

// register byte offsets on the apb bus
`define WDG_OFF_RESET_CAUSE     8'h00
`define WDG_OFF_CTRL            8'h04

// reset_cause_status field positions
`define WDG_RC_POWERON          0
`define WDG_RC_PIN              1
`define WDG_RC_BROWNOUT         2
`define WDG_RC_TIMER            3

// watchdog_control_status field positions
`define WDG_CS_PS0              0
`define WDG_CS_PS2              2
`define WDG_CS_RE               3
`define WDG_CS_CE               4
`define WDG_CS_PS3              5
`define WDG_CS_IE               6
`define WDG_CS_FLAG             7

// reset values and the largest prescale code
`define WDG_RC_RESET            4'h1
`define WDG_PS_RESET            4'h0
`define WDG_PS_MAX              4'h9

// timing: rates in hz, window in system clock cycles
`define WDG_CLK_HZ              10000000
`define WDG_OSC_HZ              128000
`define WDG_OSC_DIV             (`WDG_CLK_HZ / `WDG_OSC_HZ)
`define WDG_BASE_CYCLES         2048
`define WDG_CE_WINDOW           3'h4

`endif

// >>> hdl/wdg_osc_counter.v
/*
 * time-out counter of the supervision timer: a divider makes the
 * oscillator-rate enable, a counter counts those ticks, and a one-cycle
 * expiry pulse leaves when the selected limit is reached.
 * assumes one system clock and synchronous restart and run inputs.
 */
`timescale 1ns/1ps
`include "wdg_map.vh"

module wdg_osc_counter #(
    parameter DIV  = `WDG_OSC_DIV,      // system cycles per oscillator cycle
    parameter BASE = `WDG_BASE_CYCLES,  // oscillator cycles at prescale 0
    parameter CW   = 21                 // counter width
) (
    input  wire          clk,           // system clock
    input  wire          arst_n,        // async reset, active low
    input  wire          restart,       // counter back to zero
    input  wire          run,           // counting allowed
    input  wire [3:0]    prescale,      // time-out select
    output reg           expire         // one-cycle expiry pulse
);

    reg  [15:0]   div_reg;              // oscillator-rate divider
    reg  [CW-1:0] cnt_reg;              // oscillator cycle count
    wire          tick;                 // one-cycle oscillator enable
    wire [3:0]    ps_eff;               // prescale with reserved codes capped
    wire [CW-1:0] limit;                // last count before expiry

    assign tick   = (div_reg == DIV - 1);
    // reserved codes behave as the longest period
    assign ps_eff = (prescale > `WDG_PS_MAX) ? `WDG_PS_MAX : prescale;
    assign limit  = (BASE[CW-1:0] << ps_eff) - {{(CW-1){1'b0}}, 1'b1};

    // divider runs free so the tick rate never depends on core activity
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= 16'h0000;
        end else if (tick) begin
            div_reg <= 16'h0000;
        end else begin
            div_reg <= div_reg + 16'h0001;
        end
    end

    // counter and expiry; a shorter limit set mid-count expires at the next tick
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= {CW{1'b0}};
            expire  <= 1'b0;
        end else begin
            expire <= 1'b0;
            if (restart || !run) begin
                cnt_reg <= {CW{1'b0}};
            end else if (tick) begin
                if (cnt_reg >= limit) begin
                    cnt_reg <= {CW{1'b0}};
                    expire  <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
                end
            end
        end
    end

endmodule // wdg_osc_counter

// >>> hdl/wdg_top.v
/*
 * supervision timer with reset cause flags, reached over apb.
 * holds the control register, the timed unlock, the mode decode,
 * the expiry actions and the reset cause register.
 * assumes inputs synchronous to CLK, ARST_N as the power-on reset,
 * and other reset sources reported as one-cycle pulses.
 */
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "wdg_map.vh"

// Operation
// - count oscillator ticks, act at time-out
// - restart instruction clears the counter
// - interrupt mode: flag only, no reset
// - reset mode: system reset on expiry
// - combined: first interrupt, then reset
// - reset and irq enables select the mode
// - programmed fuse forces reset mode
// - protected change only within four cycles
// - flag set on time-out, cleared by vector
// - interrupt needs global and timer enables
// - vector in combined mode clears enable, flag
// - unserviced interrupt then next expiry resets
// - counter keeps running while asleep
// - timer reset flag: set, cleared by zero
// - brown-out flag: set, cleared by zero
// - pin reset flag: set, cleared by zero
// - power-on flag cleared only by zero write
// - upper cause bits read as zero
// - system reset pulse lasts one cycle
// - timer reset flag forces reset enable
// - change enable self-clears after four cycles
// - prescale codes 2048 to 1048576 cycles
module wdg_top #(
    parameter OSC_DIV    = `WDG_OSC_DIV,     // system cycles per tick
    parameter BASE_TICKS = `WDG_BASE_CYCLES  // ticks at prescale 0
) (
    input  wire        CLK,              // system clock, 10 MHz
    input  wire        ARST_N,           // power-on reset, active low
    input  wire        PSEL,             // apb select
    input  wire        PENABLE,          // apb access phase
    input  wire        PWRITE,           // apb direction, 1 = write
    input  wire [7:0]  PADDR,            // apb byte address
    input  wire [31:0] PWDATA,           // apb write data
    output reg  [31:0] PRDATA,           // apb read data
    output reg         PREADY,           // apb ready
    output reg         PSLVERR,          // apb error, unmapped address
    input  wire        RESTART_STROBE,   // restart instruction executed
    input  wire        VECTOR_TAKEN,     // timer interrupt vector taken
    input  wire        GLOBAL_IRQ_EN,    // global enable of status reg
    input  wire        ALWAYS_ON_FUSE_N, // 0 = fuse programmed
    input  wire        PIN_RESET_SEEN,   // pulse: pin reset happened
    input  wire        BROWNOUT_SEEN,    // pulse: brown-out happened
    output reg         TIMEOUT_IRQ,      // interrupt request to core
    output reg         SYS_RESET         // one-cycle system reset
);

    // control register fields
    reg        flag_reg;                 // timeout_irq_flag
    reg        ie_reg;                   // timeout_irq_enable as written
    reg        ce_reg;                   // change_enable_bit
    reg        re_reg;                   // reset_enable_bit as written
    reg  [3:0] ps_reg;                   // timeout_prescale_select
    reg  [2:0] ce_cnt_reg;               // cycles left in unlock window

    // reset cause flags
    reg        por_flag_reg;             // poweron_cause_flag
    reg        pin_flag_reg;             // pin_reset_cause_flag
    reg        bod_flag_reg;             // brownout_cause_flag
    reg        tmr_flag_reg;             // timer_reset_cause_flag
    localparam [3:0] RC_RESET = `WDG_RC_RESET; // cause flags after power-on

    // bus decode
    wire       access;                   // completing apb transfer
    wire       wr;                       // completing write
    wire       sel_rc;                   // reset cause selected
    wire       sel_cs;                   // control selected
    wire       wr_rc;                    // write to reset cause
    wire       wr_cs;                    // write to control

    // write data fields for the control register
    wire       wd_flag;                  // flag bit written
    wire       wd_ie;                    // irq enable written
    wire       wd_ce;                    // change enable written
    wire       wd_re;                    // reset enable written
    wire [3:0] wd_ps;                    // prescale written
    wire       unlock;                   // unlock write seen
    wire       protect_ok;               // protected change accepted

    // effective configuration
    wire       fuse_on;                  // always-on fuse programmed
    wire       re_eff;                   // reset enable after overrides
    wire       ie_eff;                   // irq enable after overrides
    wire       running;                  // any mode but stopped
    wire       combined;                 // interrupt then reset mode

    // timer events
    wire       expire;                   // counter expiry pulse
    wire       do_reset;                 // expiry leads to reset
    wire       do_irq;                   // expiry sets the flag
    wire       sys_evt;                  // any system reset this cycle
    wire [7:0] rc_rd;                    // reset cause read value
    wire [7:0] cs_rd;                    // control read value

    // apb decode; a write lands only at the edge with PREADY high
    assign access = PSEL & PENABLE & PREADY;
    assign wr     = access & PWRITE;
    assign sel_rc = (PADDR == `WDG_OFF_RESET_CAUSE);
    assign sel_cs = (PADDR == `WDG_OFF_CTRL);
    assign wr_rc  = wr & sel_rc;
    assign wr_cs  = wr & sel_cs;

    // control write fields
    assign wd_flag = PWDATA[`WDG_CS_FLAG];
    assign wd_ie   = PWDATA[`WDG_CS_IE];
    assign wd_ce   = PWDATA[`WDG_CS_CE];
    assign wd_re   = PWDATA[`WDG_CS_RE];
    assign wd_ps   = {PWDATA[`WDG_CS_PS3], PWDATA[`WDG_CS_PS2:`WDG_CS_PS0]};

    // unlock needs change and reset enable in one write
    assign unlock     = wr_cs & wd_ce & wd_re;
    // protected change: open window and change enable written low
    assign protect_ok = wr_cs & ce_reg & ~wd_ce;

    // overrides from the fuse and the timer reset flag
    assign fuse_on  = ~ALWAYS_ON_FUSE_N;
    assign re_eff   = re_reg | tmr_flag_reg | fuse_on;
    assign ie_eff   = ie_reg & ~fuse_on;
    assign running  = re_eff | ie_eff;
    assign combined = re_eff & ie_eff;

    // expiry actions per mode
    // reset: reset mode, or combined with the flag still pending
    assign do_reset = expire & re_eff & (~ie_eff | flag_reg);
    // interrupt: interrupt mode, or first expiry in combined mode
    assign do_irq   = expire & ie_eff & ~do_reset;

    // a system reset of any source, seen in the same cycle as it occurs
    assign sys_evt = SYS_RESET | PIN_RESET_SEEN | BROWNOUT_SEEN;

    // read values; upper cause bits are always zero
    assign rc_rd = {4'h0, tmr_flag_reg, bod_flag_reg,
                    pin_flag_reg, por_flag_reg};
    assign cs_rd = {flag_reg, ie_eff, ps_reg[3], ce_reg,
                    re_eff, ps_reg[2:0]};

    // time-out counter; keeps counting in every sleep state since
    // nothing here depends on the core clock being gated
    wdg_osc_counter #(
        .DIV      (OSC_DIV),
        .BASE     (BASE_TICKS),
        .CW       (21)
    ) u_cnt (
        .clk      (CLK),
        .arst_n   (ARST_N),
        .restart  (RESTART_STROBE | sys_evt),
        .run      (running),
        .prescale (ps_reg),
        .expire   (expire)
    );

    // apb slave: one wait state, then ready with data or error
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && PENABLE && !PREADY) begin
            // answer in the second access cycle
            PREADY  <= 1'b1;
            PSLVERR <= ~(sel_rc | sel_cs);
            if (PWRITE) begin
                PRDATA <= 32'h0000_0000;
            end else if (sel_rc) begin
                PRDATA <= {24'h00_0000, rc_rd};
            end else if (sel_cs) begin
                PRDATA <= {24'h00_0000, cs_rd};
            end else begin
                PRDATA <= 32'h0000_0000;
            end
        end else begin
            // ready and error stand one cycle only
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // timed unlock window; change enable drops after four cycles
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (sys_evt) begin
            // any system reset closes the window
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (unlock) begin
            ce_reg     <= 1'b1;
            ce_cnt_reg <= `WDG_CE_WINDOW;
        end else if (protect_ok) begin
            // window used up by the protected change
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (ce_cnt_reg == 3'h1) begin
            ce_reg     <= 1'b0;
            ce_cnt_reg <= 3'h0;
        end else if (ce_cnt_reg != 3'h0) begin
            ce_cnt_reg <= ce_cnt_reg - 3'h1;
        end
    end

    // reset enable and prescale, protected by the window
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            re_reg <= 1'b0;
            ps_reg <= `WDG_PS_RESET;
        end else if (sys_evt) begin
            // timer reset flag still holds the effective enable high
            re_reg <= 1'b0;
            ps_reg <= `WDG_PS_RESET;
        end else if (protect_ok) begin
            re_reg <= wd_re;
            ps_reg <= wd_ps;
        end else if (wr_cs) begin
            // outside the window reset enable may only be set
            re_reg <= re_reg | wd_re;
        end
    end

    // irq enable: free to write; vector in combined mode clears it
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ie_reg <= 1'b0;
        end else if (sys_evt) begin
            ie_reg <= 1'b0;
        end else if (wr_cs) begin
            ie_reg <= wd_ie;
        end else if (VECTOR_TAKEN && combined) begin
            ie_reg <= 1'b0;
        end
    end

    // irq flag: set by time-out, cleared by vector or a one written;
    // a time-out in the clearing cycle wins
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            flag_reg <= 1'b0;
        end else if (sys_evt) begin
            flag_reg <= 1'b0;
        end else if (do_irq) begin
            flag_reg <= 1'b1;
        end else if (VECTOR_TAKEN) begin
            flag_reg <= 1'b0;
        end else if (wr_cs && wd_flag) begin
            flag_reg <= 1'b0;
        end
    end

    // interrupt request: flag gated by both enables
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            TIMEOUT_IRQ <= 1'b0;
        end else begin
            TIMEOUT_IRQ <= flag_reg & ie_eff & GLOBAL_IRQ_EN & ~sys_evt;
        end
    end

    // system reset pulse, exactly one cycle per reset expiry
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            SYS_RESET <= 1'b0;
        end else begin
            SYS_RESET <= do_reset & ~SYS_RESET;
        end
    end

    // reset cause flags; power-on reset leaves only the power-on flag;
    // software clears by writing zero, a new cause in that cycle wins
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            por_flag_reg <= RC_RESET[`WDG_RC_POWERON];
            pin_flag_reg <= 1'b0;
            bod_flag_reg <= 1'b0;
            tmr_flag_reg <= 1'b0;
        end else begin
            // power-on flag: only a zero write clears it
            if (wr_rc && !PWDATA[`WDG_RC_POWERON]) begin
                por_flag_reg <= 1'b0;
            end
            // pin reset cause
            if (PIN_RESET_SEEN) begin
                pin_flag_reg <= 1'b1;
            end else if (wr_rc && !PWDATA[`WDG_RC_PIN]) begin
                pin_flag_reg <= 1'b0;
            end
            // brown-out cause
            if (BROWNOUT_SEEN) begin
                bod_flag_reg <= 1'b1;
            end else if (wr_rc && !PWDATA[`WDG_RC_BROWNOUT]) begin
                bod_flag_reg <= 1'b0;
            end
            // timer reset cause, set with the reset pulse
            if (do_reset && !SYS_RESET) begin
                tmr_flag_reg <= 1'b1;
            end else if (wr_rc && !PWDATA[`WDG_RC_TIMER]) begin
                tmr_flag_reg <= 1'b0;
            end
        end
    end

endmodule // wdg_top

// >>> verification/wdg_checker.sv
/* assertions on the ports of the supervision timer top.
   assumes one clock domain and the bind at the foot of this file. */
`timescale 1ns/1ps
`include "wdg_map.vh"

module wdg_checker (
    input logic        CLK,              // system clock
    input logic        ARST_N,           // reset, active low
    input logic        PSEL,             // apb select
    input logic        PENABLE,          // apb access phase
    input logic        PWRITE,           // apb direction
    input logic [7:0]  PADDR,            // apb address
    input logic [31:0] PRDATA,           // apb read data
    input logic        PREADY,           // apb ready
    input logic        PSLVERR,          // apb error
    input logic        VECTOR_TAKEN,     // vector executed
    input logic        GLOBAL_IRQ_EN,    // global enable
    input logic        ALWAYS_ON_FUSE_N, // fuse, 0 programmed
    input logic        TIMEOUT_IRQ,      // interrupt request
    input logic        SYS_RESET         // system reset pulse
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!ARST_N);

    // reset pulse is a single cycle, never repeated at once
    rst_pulse_a: assert property (SYS_RESET |=> !SYS_RESET [*4])
        else $error("system reset pulse too long");
    // request only while the global enable was set
    irq_gate_a: assert property (TIMEOUT_IRQ |-> $past(GLOBAL_IRQ_EN))
        else $error("interrupt without global enable");
    // programmed fuse locks the interrupt enable at zero
    fuse_no_irq_a: assert property (
        !ALWAYS_ON_FUSE_N && !$past(ALWAYS_ON_FUSE_N) |-> !TIMEOUT_IRQ)
        else $error("interrupt while fuse forces reset mode");
    // vector clears the flag, request drops two cycles on
    vector_clear_a: assert property (VECTOR_TAKEN |-> ##2 !TIMEOUT_IRQ)
        else $error("request still up after vector");
    // upper cause bits read as zero
    cause_upper_a: assert property (
        PREADY && !PWRITE && PADDR == `WDG_OFF_RESET_CAUSE
        |-> PRDATA[31:4] == 28'h000_0000)
        else $error("upper cause bits not zero");
    // one wait state, then ready
    ready_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("ready not in second access cycle");
    // ready stands one cycle
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    // unmapped address answered with an error
    bad_addr_a: assert property (PREADY && PADDR != `WDG_OFF_RESET_CAUSE
        && PADDR != `WDG_OFF_CTRL |-> PSLVERR && PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    // mapped address answered without error
    good_addr_a: assert property (PREADY && (PADDR == `WDG_OFF_RESET_CAUSE
        || PADDR == `WDG_OFF_CTRL) |-> !PSLVERR)
        else $error("mapped access refused");
endmodule // wdg_checker

bind wdg_top wdg_checker u_wdg_checker (.CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PRDATA, .PREADY, .PSLVERR, .VECTOR_TAKEN, .GLOBAL_IRQ_EN,
    .ALWAYS_ON_FUSE_N, .TIMEOUT_IRQ, .SYS_RESET);

// >>> verification/wdg_core_model.sv
/* core model: turns bench kicks into restart instructions and
   services the timer interrupt after a latency. assumes one clock. */
`timescale 1ns/1ps

module wdg_core_model (
    input  logic       clk,            // system clock
    input  logic       arst_n,         // reset, active low
    input  logic       irq,            // interrupt request seen
    input  logic       kick,           // bench asks for a restart
    input  logic       svc_on,         // interrupts serviced
    input  logic [3:0] svc_lat,        // cycles before the vector
    output logic       restart_strobe, // restart instruction
    output logic       vector_taken    // interrupt vector executed
);
    logic [3:0] wait_reg;              // cycles the request waited

    // restart a cycle after a kick, vector after the latency
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            restart_strobe <= 1'h0;
            vector_taken   <= 1'h0;
            wait_reg       <= 4'h0;
        end else begin
            restart_strobe <= kick;
            vector_taken   <= 1'h0;
            if (!irq || !svc_on || vector_taken)
                wait_reg <= 4'h0;
            else if (wait_reg == svc_lat) begin
                vector_taken <= 1'h1;
                wait_reg     <= 4'h0;
            end else
                wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // wdg_core_model

// >>> verification/wdg_top_tb_top.sv
/* bench of the supervision timer: apb tasks, a core model and
   access sequences with expected values. assumes short parameters. */
`timescale 1ns/1ps
`include "wdg_map.vh"

module wdg_top_tb_top;
    localparam DIV = 2;                  // shortened tick divider
    localparam BT  = 8;                  // shortened base ticks
    localparam RC  = `WDG_OFF_RESET_CAUSE;
    localparam CS  = `WDG_OFF_CTRL;
    logic        CLK, ARST_N, PSEL, PENABLE, PWRITE; // clock, reset, apb
    logic [7:0]  PADDR;                  // apb address
    logic [31:0] PWDATA, PRDATA, rd;     // apb data, last read
    logic        PREADY, PSLVERR, RESTART_STROBE, VECTOR_TAKEN, GLOBAL_IRQ_EN;
    logic        ALWAYS_ON_FUSE_N, PIN_RESET_SEEN, BROWNOUT_SEEN, TIMEOUT_IRQ;
    logic        SYS_RESET, kick, svc_on, err_seen; // outputs, model controls
    int          err_total, n_checks, cyc, n, n_rst, k;
    logic [31:0] codes [3] = '{32'h0000_0008, 32'h0000_0029, 32'h0000_002F};

    wdg_top #(.OSC_DIV(DIV), .BASE_TICKS(BT)) u_wdg_top (.CLK, .ARST_N, .PSEL,
        .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
        .RESTART_STROBE, .VECTOR_TAKEN, .GLOBAL_IRQ_EN, .ALWAYS_ON_FUSE_N,
        .PIN_RESET_SEEN, .BROWNOUT_SEEN, .TIMEOUT_IRQ, .SYS_RESET);
    wdg_core_model u_wdg_core_model (.clk(CLK), .arst_n(ARST_N), .irq(TIMEOUT_IRQ),
        .kick(kick), .svc_on(svc_on), .svc_lat(4'h3),
        .restart_strobe(RESTART_STROBE), .vector_taken(VECTOR_TAKEN));

    // 10 MHz clock
    initial begin
        CLK = 1'h0;
        forever #50 CLK = ~CLK;
    end

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // cnt apb transfers back to back, data d0 then d1
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d0,
                       input logic [31:0] d1, input int cnt);
        int i, t;
        @(posedge CLK);
        for (i = 0; i < cnt; i++) begin
            PSEL    <= 1'h1;
            PENABLE <= 1'h0;
            PWRITE  <= w;
            PADDR   <= a;
            PWDATA  <= (i == 0) ? d0 : d1;
            @(posedge CLK);
            PENABLE <= 1'h1;
            t = 0;
            do begin
                @(posedge CLK);
                t++;
            end while (PREADY !== 1'h1 && t < 20);
            rd = PRDATA;
            err_seen = PSLVERR;
            chk(PREADY, 1'h1);
        end
        PSEL    <= 1'h0;
        PENABLE <= 1'h0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d, d, 1);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000, 32'h0000_0000, 1);
        chk(rd, e);
    endtask

    // unlock write, then the protected value in the window
    task automatic unl(input logic [31:0] d);
        bus(1'h1, CS, 32'h0000_0018, d, 2);
    endtask

    task automatic restart();
        @(posedge CLK);
        kick <= 1'h1;
        @(posedge CLK);
        kick <= 1'h0;
    endtask

    // cycles until reset (w 0) or interrupt (w 1)
    task automatic wait_on(input int w, output int c);
        c = 0;
        do begin
            @(posedge CLK);
            c++;
        end while ((w ? TIMEOUT_IRQ : SYS_RESET) !== 1'h1 && c < 20000);
    endtask

    // restart, then time the expiry against the prescale
    task automatic timed(input int ps);
        restart();
        wait_on(0, n);
        chk(n >= (BT * DIV << ps) - 4 && n <= (BT * DIV << ps) + 4, 1);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // cycle ceiling and count of system resets
    always @(posedge CLK) begin
        cyc++;
        if (SYS_RESET === 1'h1)
            n_rst++;
        if (cyc == 60000) begin
            err_total++;
            $display("unexpected at %0t: cycle limit reached", $time);
            complete_run();
        end
    end

    initial begin
        {ARST_N, PSEL, PENABLE, PWRITE, kick, svc_on} = 6'h00;
        {PIN_RESET_SEEN, BROWNOUT_SEEN} = 2'h0;
        {GLOBAL_IRQ_EN, ALWAYS_ON_FUSE_N} = 2'h3;
        PADDR = 8'h00;
        PWDATA = 32'h0000_0000;
        repeat (20) @(posedge CLK);
        ARST_N <= 1'h1;
        rc(RC, 32'h0000_0001);
        rc(CS, 32'h0000_0000);
        rc(8'h08, 32'h0000_0000);
        chk(err_seen, 1'h1);
        n_rst = 0;
        repeat (100) @(posedge CLK);
        chk(n_rst + TIMEOUT_IRQ, 0);
        // interrupt mode with prescale 3
        unl(32'h0000_0043);
        rc(CS, 32'h0000_0043);
        wait_on(1, n);
        chk(n < 130, 1);
        rc(CS, 32'h0000_00C3);
        chk(n_rst, 0);
        GLOBAL_IRQ_EN <= 1'h0;
        wr(CS, 32'h0000_00C3);
        repeat (130) @(posedge CLK);
        chk(TIMEOUT_IRQ, 1'h0);
        rc(CS, 32'h0000_00C3);
        GLOBAL_IRQ_EN <= 1'h1;
        repeat (3) @(posedge CLK);
        chk(TIMEOUT_IRQ, 1'h1);
        restart();
        svc_on <= 1'h1;
        repeat (8) @(posedge CLK);
        rc(CS, 32'h0000_0043);
        svc_on <= 1'h0;
        // reset mode, prescale kept by locked writes
        wr(CS, 32'h0000_0088);
        n_rst = 0;
        repeat (20) begin
            restart();
            repeat (8) @(posedge CLK);
        end
        chk(n_rst, 0);
        wr(CS, 32'h0000_0018);
        repeat (5) @(posedge CLK);
        wr(CS, 32'h0000_0000);
        rc(CS, 32'h0000_000B);
        timed(3);
        rc(RC, 32'h0000_0009);
        rc(CS, 32'h0000_0008);
        unl(32'h0000_0000);
        rc(CS, 32'h0000_0008);
        for (k = 0; k < 3; k++) begin
            unl(codes[k]);
            timed(k == 0 ? 0 : 9);
        end
        restart();
        wr(RC, 32'h0000_0000);
        rc(RC, 32'h0000_0000);
        // combined mode, unserviced then serviced
        wr(CS, 32'h0000_0048);
        n_rst = 0;
        wait_on(1, n);
        chk(n_rst, 0);
        rc(CS, 32'h0000_00C8);
        wait_on(0, n);
        chk(n < 20, 1);
        svc_on <= 1'h1;
        wr(CS, 32'h0000_0048);
        wait_on(1, n);
        repeat (6) @(posedge CLK);
        rc(CS, 32'h0000_0008);
        wait_on(0, n);
        chk(n < 20, 1);
        svc_on <= 1'h0;
        restart();
        wr(RC, 32'h0000_0000);
        // pin and brown-out cause flags
        PIN_RESET_SEEN <= 1'h1;
        @(posedge CLK);
        PIN_RESET_SEEN <= 1'h0;
        BROWNOUT_SEEN <= 1'h1;
        @(posedge CLK);
        BROWNOUT_SEEN <= 1'h0;
        rc(RC, 32'h0000_0006);
        wr(RC, 32'h0000_000B);
        rc(RC, 32'h0000_0002);
        // fuse forces reset mode
        ALWAYS_ON_FUSE_N <= 1'h0;
        wr(CS, 32'h0000_0040);
        rc(CS, 32'h0000_0008);
        timed(0);
        // second power-on reset
        ARST_N <= 1'h0;
        repeat (3) @(posedge CLK);
        ALWAYS_ON_FUSE_N <= 1'h1;
        ARST_N <= 1'h1;
        rc(RC, 32'h0000_0001);
        complete_run();
    end
endmodule // wdg_top_tb_top
